// ### rtl/rbd_params.svh
// constants for the rds/rbds block decoder and band level detector
`ifndef RBD_PARAMS_SVH
`define RBD_PARAMS_SVH
// clocks and rates
`define RBD_CLK_HZ      200000000
`define RBD_SMP_HZ      228000
`define RBD_NS_PER_S    1000000000
`define RBD_US_PER_S    1000000
// level detector
`define RBD_TAU_US      6750
`define RBD_NOTCH_HZ    54
`define RBD_ONE_Q16     65536
`define RBD_TWO_PI_Q16  411775
`define RBD_LVL_GAIN    16'h0002
`define RBD_LVL_MAX     8'hFF
// bit clock phase jumps
`define RBD_BIT_PER_NS  842000
`define RBD_JUMP_DIV    8
`define RBD_SLIP_THR    4'sh2
// block code
`define RBD_BLK_LEN     5'h1A
`define RBD_POLY        10'h1B9
`define RBD_OFS_A       10'h0FC
`define RBD_OFS_B       10'h198
`define RBD_OFS_C       10'h168
`define RBD_OFS_CP      10'h350
`define RBD_OFS_D       10'h1B4
`define RBD_OFS_E       10'h000
// block identification codes
`define RBD_ID_A        3'h0
`define RBD_ID_B        3'h1
`define RBD_ID_C        3'h2
`define RBD_ID_CP       3'h3
`define RBD_ID_D        3'h4
`define RBD_ID_E        3'h5
// correction modes as {high, low}
`define RBD_CM_NONE     2'h0
`define RBD_CM_TWO      2'h1
`define RBD_CM_FIVE     2'h2
`define RBD_CM_DEFER    2'h3
// correction status and burst limits
`define RBD_ST_CLEAN    2'h0
`define RBD_ST_TWO      2'h1
`define RBD_ST_FIVE     2'h2
`define RBD_ST_BAD      2'h3
`define RBD_BURST_NONE  3'h0
`define RBD_BURST_TWO   3'h2
`define RBD_BURST_FIVE  3'h5
`define RBD_NO_FIX      3'h7
`endif

// ### rtl/rbd_pkg.sv
// types shared by the rds/rbds decoder modules
package rbd_pkg;
  typedef enum logic [1:0] {
    rbd_st_search,
    rbd_st_second,
    rbd_st_synced
  } rbd_state_e;
  typedef logic [2:0] rbd_blk_id_t;
  typedef struct packed {
    logic [15:0] data;
    logic        correction_status_high;
    logic        correction_status_low;
    rbd_blk_id_t block_ident_field;
    logic        valid;
  } rbd_blk_s;
endpackage

// ### rtl/rbd_level_if.sv
// carrier between the decoder top and the band level detector
`timescale 1ns/1ps
`default_nettype none
interface rbd_level_if;
  logic signed [15:0] sample;
  logic               valid;
  logic [7:0]         level;
  modport src (output sample, output valid, input level);
  modport det (input sample, input valid, output level);
endinterface
`default_nettype wire

// ### rtl/rbd_level_det.sv
// rds band level detector: ari notch, rectifier and averaging filter
`timescale 1ns/1ps
`default_nettype none
`include "rbd_params.svh"

module rbd_level_det (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // samples in, level out
  rbd_level_if.det  lv
);
  import rbd_pkg::*;

  // filter weights in q16
  localparam logic [15:0] NOTCH_A = 16'((64'd`RBD_TWO_PI_Q16
    * 64'd`RBD_NOTCH_HZ) / 64'd`RBD_SMP_HZ);
  localparam logic [15:0] AVG_A = 16'((64'd`RBD_ONE_Q16
    * 64'd`RBD_US_PER_S) / (64'd`RBD_TAU_US * 64'd`RBD_SMP_HZ));

  logic [1:0]         phase;
  logic signed [16:0] mix_i;
  logic signed [16:0] mix_q;
  logic signed [47:0] dc_i;
  logic signed [47:0] dc_q;
  logic signed [47:0] err_i;
  logic signed [47:0] err_q;
  logic signed [47:0] mag;
  logic signed [47:0] avg;
  logic signed [47:0] avg_err;
  logic [47:0]        scaled;

  // mix the 57 kHz carrier to dc, sample rate is four times it
  always_comb begin
    mix_i = 17'sh0;
    mix_q = 17'sh0;
    case (phase)
      2'h0: mix_i = 17'(lv.sample);
      2'h1: mix_q = 17'(lv.sample);
      2'h2: mix_i = -17'(lv.sample);
      default: mix_q = -17'(lv.sample);
    endcase
  end

  // notch output, rectified per active channel, scaled level
  // the idle channel holds a zero, so tracking it would leave half
  // the carrier in the residual; only the channel in use is measured
  assign err_i = (48'(mix_i) <<< 16) - dc_i;
  assign err_q = (48'(mix_q) <<< 16) - dc_q;
  assign mag = phase[0] ? (err_q < 0 ? -err_q : err_q)
                        : (err_i < 0 ? -err_i : err_i);
  assign avg_err = mag - avg;
  assign scaled = 48'(((avg >>> 16) * `RBD_LVL_GAIN) >>> 8);

  // narrow carrier trackers and the averaging filter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
      dc_i  <= 48'sh0;
      dc_q  <= 48'sh0;
      avg   <= 48'sh0;
    end else if (lv.valid) begin
      phase <= phase + 2'h1;
      // each tracker sees every other sample, so its step is doubled
      if (phase[0]) begin
        dc_q <= dc_q + ((err_q * $signed({1'b0, NOTCH_A})) >>> 15);
      end else begin
        dc_i <= dc_i + ((err_i * $signed({1'b0, NOTCH_A})) >>> 15);
      end
      avg   <= avg + ((avg_err * $signed({1'b0, AVG_A})) >>> 16);
    end
  end

  // 8-bit fraction of full scale, clipped at the top code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lv.level <= 8'h00;
    end else if (scaled > 48'(`RBD_LVL_MAX)) begin
      lv.level <= `RBD_LVL_MAX;
    end else begin
      lv.level <= scaled[7:0];
    end
  end

  chk_level_clip: assert property (
    @(posedge clk) disable iff (!rst_b)
    (scaled > 48'(`RBD_LVL_MAX)) |=> (lv.level == `RBD_LVL_MAX))
    else $error("level did not clip at the top code");

  chk_level_follow: assert property (
    @(posedge clk) disable iff (!rst_b)
    (scaled <= 48'(`RBD_LVL_MAX)) |=> (lv.level == $past(scaled[7:0])))
    else $error("level does not follow the averaged value");
endmodule
`default_nettype wire

// ### rtl/rbd_decoder.sv
// rds/rbds block decoder with bit slip handshake and band level output
`timescale 1ns/1ps
`default_nettype none
`include "rbd_params.svh"

module rbd_decoder #(
  parameter int unsigned BIT_CYC = 32'((64'd`RBD_BIT_PER_NS
    * 64'd`RBD_CLK_HZ) / 64'd`RBD_NS_PER_S)
) (
  // system clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // band filtered samples
  input  wire logic signed [15:0] band_sample,
  input  wire logic               band_valid,
  // demodulator link
  input  wire logic               demod_bit_clock,
  input  wire logic               demod_bit_stream,
  // controls from the memory map
  input  wire logic               correction_select_low,
  input  wire logic               correction_select_high,
  input  wire logic               rbds_mode,
  input  wire logic               sync_restart,
  // results to the memory map
  output logic [7:0]              band_level_register,
  output logic                    slip_flag,
  output logic                    slip_acknowledge,
  output logic                    sync_status,
  output rbd_pkg::rbd_blk_s       last_block,
  output rbd_pkg::rbd_blk_s       prev_block
);
  import rbd_pkg::*;

  localparam logic [4:0] BLK = `RBD_BLK_LEN;
  localparam logic [31:0] JUMP_TOL = 32'(BIT_CYC / `RBD_JUMP_DIV);
  localparam logic [31:0] PER_LO = 32'(BIT_CYC) - JUMP_TOL;
  localparam logic [31:0] PER_HI = 32'(BIT_CYC) + JUMP_TOL;

  // remainder of a 26-bit word by the block generator
  function automatic logic [9:0] rbd_synd(input logic [25:0] w);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 25; i >= 0; i--) begin
      r = {r[8:0], w[i]} ^ (r[9] ? `RBD_POLY : 10'h000);
    end
    return r;
  endfunction

  // offset word of each block kind
  function automatic logic [9:0] rbd_ofs(input rbd_blk_id_t id);
    case (id)
      `RBD_ID_A:  return `RBD_OFS_A;
      `RBD_ID_B:  return `RBD_OFS_B;
      `RBD_ID_C:  return `RBD_OFS_C;
      `RBD_ID_CP: return `RBD_OFS_CP;
      `RBD_ID_D:  return `RBD_OFS_D;
      default:    return `RBD_OFS_E;
    endcase
  endfunction

  // block kind that follows in the a b c d order
  function automatic rbd_blk_id_t rbd_next(input rbd_blk_id_t id);
    case (id)
      `RBD_ID_A: return `RBD_ID_B;
      `RBD_ID_B: return `RBD_ID_C;
      `RBD_ID_D: return `RBD_ID_A;
      default:   return `RBD_ID_D;
    endcase
  endfunction

  // ************************************************************
  // level detector
  // ************************************************************
  rbd_level_if lvl ();

  assign lvl.sample = band_sample;
  assign lvl.valid = band_valid;
  assign band_level_register = lvl.level;

  rbd_level_det u_level (
    .clk   (clk),
    .rst_b (rst_b),
    .lv    (lvl.det)
  );

  // ************************************************************
  // link clock domain and crossing
  // ************************************************************
  logic       link_bit;
  logic       link_tgl;
  logic [2:0] tgl_sync;
  logic       tgl_seen;
  logic       bit_evt;

  // capture each bit and mark it by a toggle
  always_ff @(posedge demod_bit_clock or negedge rst_b) begin
    if (!rst_b) begin
      link_bit <= 1'b0;
      link_tgl <= 1'b0;
    end else begin
      link_bit <= demod_bit_stream;
      link_tgl <= ~link_tgl;
    end
  end

  // three stage toggle synchroniser, stage 0 feeds stage 1 only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_sync <= 3'h0;
      tgl_seen <= 1'b0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], link_tgl};
      if (bit_evt) begin
        tgl_seen <= tgl_sync[2];
      end
    end
  end

  // new bit once stages one and two agree on a fresh level
  assign bit_evt = (tgl_sync[1] == tgl_sync[2]) && (tgl_sync[2] != tgl_seen);

  // ************************************************************
  // bit clock phase jump accumulator
  // ************************************************************
  logic [31:0]       per_cnt;
  logic signed [3:0] slip_acc;
  logic signed [3:0] next_acc;
  logic              jump_up;
  logic              jump_dn;

  assign jump_dn = bit_evt && (per_cnt < PER_LO);
  assign jump_up = bit_evt && (per_cnt > PER_HI);

  // count clk cycles between bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt <= 32'h0;
    end else if (bit_evt) begin
      per_cnt <= 32'h1;
    end else if (per_cnt != 32'hFFFFFFFF) begin
      per_cnt <= per_cnt + 32'h1;
    end
  end

  // acknowledge restarts the sum, jumps move it one step
  always_comb begin
    next_acc = slip_acknowledge ? 4'sh0 : slip_acc;
    if (jump_up && next_acc <= `RBD_SLIP_THR) begin
      next_acc = next_acc + 4'sh1;
    end else if (jump_dn && next_acc >= -`RBD_SLIP_THR) begin
      next_acc = next_acc - 4'sh1;
    end
  end

  // accumulator and slip flag toward the decoder
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slip_acc  <= 4'sh0;
      slip_flag <= 1'b0;
    end else begin
      slip_acc  <= next_acc;
      slip_flag <= (next_acc > `RBD_SLIP_THR)
                || (next_acc < -`RBD_SLIP_THR);
    end
  end

  // ************************************************************
  // block detection and correction
  // ************************************************************
  rbd_state_e  state;
  rbd_blk_id_t exp_id;
  logic [4:0]  bcnt;
  logic [25:0] sr;
  logic        chk;
  logic [9:0]  syn;
  logic [9:0]  err_syn;
  logic        alt_cp;
  logic        exact;
  logic        e_hit;
  logic        hit;
  rbd_blk_id_t hit_id;
  logic [2:0]  fix_len;
  logic [25:0] fix_pat;
  logic [2:0]  lim;
  rbd_blk_s    blk;
  logic [1:0]  stat;
  logic        early;
  logic        take;

  // syndrome of the last 26 bits, every bit in every mode
  assign syn = rbd_synd(sr);
  assign err_syn = syn ^ rbd_ofs(exp_id);
  assign alt_cp = (exp_id == `RBD_ID_C) && (syn == `RBD_OFS_CP);
  assign exact = (err_syn == 10'h000) || alt_cp;
  assign e_hit = (syn == `RBD_OFS_E);

  // search: error free match of any a to d offset
  always_comb begin
    hit = 1'b0;
    hit_id = `RBD_ID_A;
    for (int i = 4; i >= 0; i--) begin
      if (syn == rbd_ofs(3'(i))) begin
        hit = 1'b1;
        hit_id = 3'(i);
      end
    end
  end

  // burst trapping: shortest pattern that explains the syndrome
  always_comb begin
    fix_len = `RBD_BURST_NONE;
    fix_pat = 26'h0;
    if (err_syn != 10'h000) begin
      fix_len = `RBD_NO_FIX;
      for (int b = 1; b < 32; b += 2) begin
        for (int p = 0; p < 26; p++) begin
          if (fix_len == `RBD_NO_FIX
              && rbd_synd(26'(b) << p) == err_syn) begin
            fix_pat = 26'(b) << p;
            fix_len = b > 15 ? 3'h5 : b > 7 ? 3'h4 : b > 3 ? 3'h3
                    : b > 1 ? 3'h2 : 3'h1;
          end
        end
      end
    end
  end

  // burst allowed by mode and sync state, bits taken high first
  always_comb begin
    case ({correction_select_high, correction_select_low})
      `RBD_CM_TWO:   lim = `RBD_BURST_TWO;
      `RBD_CM_FIVE:  lim = `RBD_BURST_FIVE;
      `RBD_CM_DEFER: lim = (state == rbd_st_synced)
                         ? `RBD_BURST_FIVE : `RBD_BURST_NONE;
      default:       lim = `RBD_BURST_NONE;
    endcase
  end

  // block as it will be recorded
  always_comb begin
    blk.data = sr[25:10];
    blk.block_ident_field = alt_cp ? `RBD_ID_CP : exp_id;
    blk.valid = 1'b1;
    stat = `RBD_ST_CLEAN;
    if (state == rbd_st_search) begin
      blk.block_ident_field = hit_id;
    end else if (exact) begin
      stat = `RBD_ST_CLEAN;
    end else if (e_hit) begin
      blk.block_ident_field = `RBD_ID_E;
      blk.valid = rbds_mode;
    end else if (fix_len <= lim) begin
      blk.data = sr[25:10] ^ fix_pat[25:10];
      stat = fix_len <= `RBD_BURST_TWO ? `RBD_ST_TWO : `RBD_ST_FIVE;
    end else begin
      stat = `RBD_ST_BAD;
      blk.valid = 1'b0;
    end
    blk.correction_status_high = stat[1];
    blk.correction_status_low = stat[0];
  end

  // one bit early under a pending slip, or late when on time fails
  assign early = chk && slip_flag && (state == rbd_st_synced)
              && (bcnt == BLK - 5'h1) && exact;
  always_comb begin
    case (state)
      rbd_st_search: take = chk && (bcnt >= BLK) && hit;
      rbd_st_second: take = chk && (bcnt == BLK);
      default: take = early || (chk && bcnt == BLK
                        && !(slip_flag && !exact))
                   || (chk && bcnt == BLK + 5'h1);
    endcase
  end

  // shift register and evaluation strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sr  <= 26'h0;
      chk <= 1'b0;
    end else begin
      chk <= bit_evt;
      if (bit_evt) begin
        sr <= {sr[24:0], link_bit};
      end
    end
  end

  // bits since the last block boundary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bcnt <= 5'h0;
    end else if (sync_restart) begin
      bcnt <= 5'h0;
    end else if (take && !(state == rbd_st_second && !blk.valid)) begin
      bcnt <= 5'h0;
    end else if (bit_evt && bcnt != BLK + 5'h1) begin
      bcnt <= bcnt + 5'h1;
    end
  end

  // synchronisation sequence and expected block
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state  <= rbd_st_search;
      exp_id <= `RBD_ID_A;
    end else if (sync_restart) begin
      state  <= rbd_st_search;
    end else if (take) begin
      case (state)
        rbd_st_search: begin
          state  <= rbd_st_second;
          exp_id <= rbd_next(hit_id);
        end
        rbd_st_second: begin
          state  <= blk.valid ? rbd_st_synced : rbd_st_search;
          exp_id <= rbd_next(blk.block_ident_field);
        end
        default: begin
          exp_id <= rbd_next(exp_id);
        end
      endcase
    end
  end

  // two most recent blocks for the host
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_block <= '0;
      prev_block <= '0;
    end else if (take) begin
      last_block <= blk;
      prev_block <= last_block;
    end
  end

  // slip acknowledge pulse and sync status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slip_acknowledge <= 1'b0;
      sync_status      <= 1'b0;
    end else begin
      slip_acknowledge <= early || (take && state == rbd_st_synced
                          && bcnt == BLK + 5'h1 && exact);
      sync_status      <= (state == rbd_st_synced);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_slip_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    slip_acknowledge |=> !slip_flag)
    else $error("slip flag survived its acknowledge");

  chk_slip_cause: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(slip_flag) |-> $past(jump_up || jump_dn))
    else $error("slip flag rose without a phase jump");

  chk_ack_synced: assert property (
    @(posedge clk) disable iff (!rst_b)
    slip_acknowledge |-> $past(state == rbd_st_synced) && $past(slip_flag))
    else $error("slip acknowledged outside a synced slip");

  chk_first_clean: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == rbd_st_search && take) |=>
      !last_block.correction_status_high && !last_block.correction_status_low)
    else $error("first block during search was corrected");

  chk_e_valid: assert property (
    @(posedge clk) disable iff (!rst_b)
    (take && blk.block_ident_field == `RBD_ID_E) |=>
      (last_block.valid == $past(rbds_mode)))
    else $error("e block validity does not follow the mode");

  chk_two_limit: assert property (
    @(posedge clk) disable iff (!rst_b)
    (take && {correction_select_high, correction_select_low} == `RBD_CM_TWO)
      |=> !(last_block.correction_status_high
            && !last_block.correction_status_low))
    else $error("five bit fix reported in two bit mode");

  chk_sync_gain: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == rbd_st_second && take && blk.valid && !sync_restart)
      |-> ##2 sync_status)
    else $error("second valid block did not give sync");

  chk_block_span: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state == rbd_st_synced && take && !slip_flag) |-> (bcnt == BLK))
    else $error("synced block taken off the 26 bit span");

  chk_history: assert property (
    @(posedge clk) disable iff (!rst_b)
    take |=> (prev_block == $past(last_block)) && (last_block == $past(blk)))
    else $error("block history not shifted");

  chk_bad_burst: assert property (
    @(posedge clk) disable iff (!rst_b)
    (take && state == rbd_st_synced && !exact && !e_hit
      && fix_len > `RBD_BURST_FIVE) |=>
      last_block.correction_status_high && last_block.correction_status_low)
    else $error("long burst not marked uncorrectable");
endmodule
`default_nettype wire

// ### test/rbd_demod_model.sv
// demodulator model: bit clock and serial block stream toward the decoder
`timescale 1ns/1ps
`default_nettype none
`include "rbd_params.svh"

module rbd_demod_model (
  // link toward the decoder
  output var logic bit_clock,
  output var logic bit_stream
);
  // ****************************************
  // block source
  // ****************************************
  // clock stands still between bursts
  initial begin
    bit_clock  = 1'b0;
    bit_stream = 1'b0;
  end

  // data plus check word, standard generator and offset
  function automatic logic [25:0] word(input logic [15:0] d,
                                       input logic [9:0]  o);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 15; i >= 0; i--) begin
      r = {r[8:0], 1'b0} ^ ((d[i] ^ r[9]) ? `RBD_POLY : 10'h000);
    end
    return {d, r ^ o};
  endfunction

  // bits top..0, first bit first, data set while the clock is low
  task automatic send(input logic [25:0] w, input int top, input int half);
    for (int i = top; i >= 0; i--) begin
      bit_stream = w[i];
      #(half) bit_clock = 1'b1;
      #(half) bit_clock = 1'b0;
    end
    bit_stream = ~w[0]; // released line shows no stale value
  endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the rds/rbds block decoder
`timescale 1ns/1ps
`default_nettype none
`include "rbd_params.svh"
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("unexpected at %0t: %s", $time, m); end end

module testbench;
  import rbd_pkg::*;
  // ****************************************
  // design, partner and stimulus
  // ****************************************
  logic               clk, rst_b, band_valid, bclk, bdat;
  logic signed [15:0] band_sample;
  logic               sel_lo, sel_hi, rbds, restart;
  logic [7:0]         level;
  logic               flag, ack, synced;
  rbd_blk_s           last_b, prev_b;
  int                 n_fail, total_checks, n_ack;
  logic [9:0]         ofs [4] = '{`RBD_OFS_A, `RBD_OFS_B, `RBD_OFS_C,
                                  `RBD_OFS_D};
  logic [2:0]         ids [4] = '{`RBD_ID_A, `RBD_ID_B, `RBD_ID_C, `RBD_ID_D};
  logic [1:0]         md [6] = '{`RBD_CM_TWO, `RBD_CM_TWO, `RBD_CM_FIVE,
                                 `RBD_CM_DEFER, `RBD_CM_FIVE, `RBD_CM_NONE};
  logic [25:0]        er [6] = '{26'h3, 26'h1F00, 26'h1F00, 26'h1F00,
                                 26'h3FF, 26'h3};
  logic [1:0]         ex [6] = '{2'h1, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [1:0]         sm [3] = '{`RBD_CM_TWO, `RBD_CM_NONE, `RBD_CM_DEFER};
  logic [1:0]         ss [3] = '{2'h1, 2'h3, 2'h3};
  logic signed [15:0] car [4] = '{16'sh0, 16'sh4E20, 16'sh0, -16'sh4E20};

  rbd_decoder #(.BIT_CYC(16)) u_dut (
    .clk(clk), .rst_b(rst_b), .band_sample(band_sample),
    .band_valid(band_valid), .demod_bit_clock(bclk),
    .demod_bit_stream(bdat), .correction_select_low(sel_lo),
    .correction_select_high(sel_hi), .rbds_mode(rbds),
    .sync_restart(restart), .band_level_register(level),
    .slip_flag(flag), .slip_acknowledge(ack), .sync_status(synced),
    .last_block(last_b), .prev_block(prev_b));
  rbd_demod_model u_demod (.bit_clock(bclk), .bit_stream(bdat));

  // system clock and acknowledge pulse counter
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (ack === 1'b1) n_ack++;

  // reset with a chosen correction mode {high, low}
  task automatic restart_dut(input logic [1:0] m);
    @(negedge clk);
    rst_b = 1'b0;
    {sel_hi, sel_lo} = m;
    rbds = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
  endtask

  // one block, result read before the next block arrives
  task automatic tx(input logic [15:0] d, input logic [9:0] o,
                    input logic [2:0] id, input logic [25:0] e,
                    input logic [1:0] st, input logic v, input int top);
    u_demod.send(u_demod.word(d, o) ^ e, top, 40);
    if (st == `RBD_ST_BAD)
      `CHK({last_b[5:4], last_b[0]}, {st, v}, "bad block status")
    else
      `CHK(last_b, rbd_blk_s'({d, st, id, v}), "block result")
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  // test sequence
  initial begin
    {rst_b, band_valid, sel_lo, sel_hi, rbds, restart} = '0;
    band_sample = '0;
    restart_dut(`RBD_CM_NONE);
    `CHK({synced, flag, ack, level, last_b, prev_b}, '0, "reset")
    u_demod.send(26'h1A5, 8, 40);
    u_demod.send(u_demod.word(16'h1234, `RBD_OFS_A), 25, 40);
    tx(16'h5678, `RBD_OFS_B, `RBD_ID_B, '0, 2'h0, 1'b1, 25);
    `CHK(synced, 1'b1, "sync")
    `CHK(prev_b, rbd_blk_s'({16'h1234, 5'h0, 1'b1}), "prev")
    tx(16'h9ABC, `RBD_OFS_C, `RBD_ID_C, '0, 2'h0, 1'b1, 25);
    tx(16'hDEF0, `RBD_OFS_D, `RBD_ID_D, '0, 2'h0, 1'b1, 25);
    tx(16'h0E0E, `RBD_OFS_E, `RBD_ID_E, '0, 2'h0, 1'b0, 25);
    rbds = 1'b1;
    tx(16'h0E1E, `RBD_OFS_E, `RBD_ID_E, '0, 2'h0, 1'b1, 25);
    tx(16'h4321, `RBD_OFS_CP, `RBD_ID_CP, '0, 2'h0, 1'b1, 25);
    // every correction mode against bursts of several lengths
    for (int i = 0; i < 6; i++) begin
      {sel_hi, sel_lo} = md[i];
      tx(16'(i * 4369), ofs[(i + 3) % 4], ids[(i + 3) % 4], er[i], ex[i],
         ex[i] != `RBD_ST_BAD, 25);
    end
    // fast bits raise the slip flag, a one bit short block is acknowledged
    u_demod.send(u_demod.word(16'h2222, `RBD_OFS_B), 25, 30);
    repeat (2) @(negedge clk);
    `CHK(flag, 1'b1, "slip flag")
    n_ack = 0;
    tx(16'h3333, `RBD_OFS_C, `RBD_ID_C, '0, 2'h0, 1'b1, 24);
    `CHK(n_ack, 1, "ack count")
    `CHK(flag, 1'b0, "flag cleared")
    restart = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(synced, 1'b0, "restart")
    restart = 1'b0;
    // second block during search, corrected per mode
    for (int i = 0; i < 3; i++) begin
      restart_dut(sm[i]);
      u_demod.send(u_demod.word(16'h5555, `RBD_OFS_A), 25, 40);
      tx(16'h6666, `RBD_OFS_B, `RBD_ID_B, 26'h3, ss[i], ss[i] == 2'h1,
         25);
      `CHK(synced, ss[i] == 2'h1, "search sync")
    end
    // level: pure carrier is notched, full scale saturates slowly
    for (int i = 0; i < 34000; i++) begin
      @(negedge clk);
      band_valid = 1'b1;
      band_sample = (i < 20000) ? car[i % 4] :
                    ((i % 2) ? -16'sd32767 : 16'sd32767);
      if (i == 19999) `CHK(level < 8'h20, 1'b1, "notch")
      if (i == 20100) `CHK(level < 8'h80, 1'b1, "smoothing")
    end
    `CHK(level, `RBD_LVL_MAX, "saturate")
    print_verdict();
  end
endmodule
`default_nettype wire
